// ===== shared/sptx_pkg.sv
// sptx_pkg: constants, enums and carrier structs of the transmit input stage.
// assumes one clock domain inside; all pins are synchronised by the user module.
package sptx_pkg;

    // ********************************
    // sizes and timing counts
    // ********************************
    localparam int NCH = 4;                        // channel count, A is index 0
    localparam logic [8:0] BIST_LAST = 9'h1fe;      // 511 character times per pass
    localparam logic [1:0] RECENTER_ARM = 2'h1;     // second low sample starts recenter
    localparam logic [1:0] RECENTER_SAT = 2'h2;     // low-sample counter ceiling
    localparam logic [2:0] OCC_TOP = 3'h2;          // fill offset at overflow edge
    localparam logic [2:0] OCC_BOT = 3'h6;          // fill offset -2, underflow edge
    localparam logic [2:0] OCC_CENTER = 3'h0;       // offset zero is the centred fill

    // ********************************
    // codes
    // ********************************
    localparam logic [7:0] VIOL_BYTE = 8'he0;       // C0.7 command byte
    localparam logic [1:0] MODE_BYPASS = 2'h0;      // encoder mode low: 10-bit raw

    // three-level static controls
    typedef enum logic [1:0] {
        LVL_LOW = 2'b00,
        LVL_MID = 2'b01,
        LVL_HIGH = 2'b10
    } sptx_lvl_t;

    // character class handed to the encoder
    typedef enum logic [1:0] {
        K_DATA = 2'b00,
        K_SPECIAL = 2'b01,
        K_FILL = 2'b10,
        K_WSYNC = 2'b11
    } sptx_kind_t;

    // ********************************
    // carriers
    // ********************************
    // one sample of every input pin
    typedef struct packed {
        logic ref_clk;
        logic [NCH-1:0] chan_clk;
        logic [NCH-1:0][7:0] chr;
        logic [NCH-1:0][1:0] ctl;
        logic [NCH-1:0] par;
        logic [NCH-1:0] bist_en;
        logic sc;
        sptx_lvl_t clk_sel;
        logic half_rate;
        logic [1:0] mode;
        sptx_lvl_t par_ctl;
        logic recenter_n;
    } sptx_pins_t;

    // per-channel state
    typedef struct packed {
        logic valid;
        logic viol;
        sptx_kind_t kind;
        logic sc;
        logic [9:0] word;
        logic par_pend;
        logic [8:0] bist_cnt;
        logic [2:0] occ;
        logic align_flt;
        logic fault;
    } sptx_chan_t;

    // whole module state
    typedef struct packed {
        sptx_pins_t s1;
        sptx_pins_t s2;
        logic ref_prev;
        logic [NCH-1:0] clk_prev;
        logic [1:0] low_cnt;
        sptx_chan_t [NCH-1:0] ch;
    } sptx_state_t;

endpackage

// ===== core/sptx_input_stage.sv
// sptx_input_stage: four-channel transmit input register, parity check and fault reporting.
// assumes every pin is asynchronous to clk and far slower (link clocks near 80 ns).
`timescale 1ns/1ps
module sptx_input_stage
    import sptx_pkg::*;
#(
    parameter logic [9:0] VIOL_LINE_CODE = 10'h000 // line code sent for C0.7 in bypass
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link clocks, sampled as plain pins
    input wire logic ref_clock_in,
    input wire logic [NCH-1:0] chan_input_clock,
    // host character interface
    input wire logic [NCH-1:0][7:0] chan_char_in,
    input wire logic [NCH-1:0][1:0] chan_ctl_bits,
    input wire logic [NCH-1:0] chan_odd_par_in,
    input wire logic special_char_sel,
    // static configuration
    input wire sptx_lvl_t input_clock_select,
    input wire logic ref_half_rate,
    input wire logic [1:0] encoder_mode_sel,
    input wire sptx_lvl_t parity_check_ctl,
    input wire logic phase_buffer_recenter_n,
    input wire logic [NCH-1:0] chan_bist_en,
    // status
    output logic [NCH-1:0] chan_fault_out,
    // characters towards encoder or shifter
    output logic [NCH-1:0][9:0] chan_word_out,
    output logic [NCH-1:0] chan_word_valid,
    output sptx_kind_t [NCH-1:0] chan_word_kind,
    output logic [NCH-1:0] chan_word_viol,
    output logic [NCH-1:0] chan_sc_out
);

    // ********************************
    // state and event decode
    // ********************************
    sptx_state_t q; // registered state
    sptx_state_t n; // next state
    sptx_pins_t pins; // raw pin bundle
    logic ref_rise; // reference rising edge seen
    logic ref_fall; // reference falling edge seen
    logic ref_tick; // one character period boundary
    logic buf_en; // phase-align buffer in use
    logic recenter; // recenter fires this cycle
    logic enc; // encoder enabled
    logic [NCH-1:0] clk_rise; // per-channel input clock rise
    logic [NCH-1:0] cap_ev; // character capture strobe
    logic [NCH-1:0] sc_ev; // special select capture strobe

    assign pins = '{ref_clk: ref_clock_in, chan_clk: chan_input_clock, chr: chan_char_in,
                    ctl: chan_ctl_bits, par: chan_odd_par_in, bist_en: chan_bist_en,
                    sc: special_char_sel, clk_sel: input_clock_select, half_rate: ref_half_rate,
                    mode: encoder_mode_sel, par_ctl: parity_check_ctl,
                    recenter_n: phase_buffer_recenter_n};

    // edges are taken from the second synchroniser stage only
    assign ref_rise = q.s2.ref_clk & ~q.ref_prev;
    assign ref_fall = ~q.s2.ref_clk & q.ref_prev;
    // half rate: both reference edges mark a character
    assign ref_tick = ref_rise | (q.s2.half_rate & ref_fall);
    assign buf_en = (q.s2.clk_sel != LVL_LOW) | q.s2.half_rate;
    // two consecutive low samples on reference rises start the recenter
    assign recenter = buf_en & ref_rise & ~q.s2.recenter_n & (q.low_cnt == RECENTER_ARM);
    assign enc = q.s2.mode != MODE_BYPASS;
    assign clk_rise = q.s2.chan_clk & ~q.clk_prev;

    // ********************************
    // per-channel strobes and outputs
    // ********************************
    for (genvar g = 0; g < NCH; g++) begin : g_chan
        // low: reference, mid: own clock, high: channel A clock
        assign cap_ev[g] = (q.s2.clk_sel == LVL_LOW) ? ref_tick :
                           (q.s2.clk_sel == LVL_MID) ? clk_rise[g] : clk_rise[0];
        // independent clocks: special select rides channel A clock
        assign sc_ev[g] = (q.s2.clk_sel == LVL_MID) ? clk_rise[0] : cap_ev[g];
        assign chan_fault_out[g] = q.ch[g].fault;
        assign chan_word_out[g] = q.ch[g].word;
        assign chan_word_valid[g] = q.ch[g].valid;
        assign chan_word_kind[g] = q.ch[g].kind;
        assign chan_word_viol[g] = q.ch[g].viol;
        assign chan_sc_out[g] = q.ch[g].sc;
    end

    // ********************************
    // next-state logic
    // ********************************
    // all channels share one loop so that the state stays one struct
    always_comb begin
        logic bad; // parity failure on this capture
        logic wsync; // atomic word sync accepted
        logic ovf; // buffer would overfill
        logic unf; // buffer would run dry
        logic bist_hit; // end of a bist pass
        logic [1:0] cbits; // control bits joined into parity
        sptx_kind_t k; // class of the captured character
        bad = 1'b0;
        wsync = 1'b0;
        ovf = 1'b0;
        unf = 1'b0;
        bist_hit = 1'b0;
        cbits = 2'b00;
        k = K_DATA;
        n = q;
        // two-stage pin synchroniser, stage one feeds stage two only
        n.s1 = pins;
        n.s2 = q.s1;
        n.ref_prev = q.s2.ref_clk;
        n.clk_prev = q.s2.chan_clk;
        // count consecutive low samples of recenter on reference rises
        if (ref_rise) begin
            if (q.s2.recenter_n) begin
                n.low_cnt = 2'h0;
            end else if (q.low_cnt != RECENTER_SAT) begin
                n.low_cnt = q.low_cnt + 2'h1;
            end
        end
        for (int i = 0; i < NCH; i++) begin
            // special select is held until its own strobe
            if (sc_ev[i]) begin
                n.ch[i].sc = q.s2.sc;
            end
            // control bits join parity in bypass or with check high
            cbits = (!enc || q.s2.par_ctl == LVL_HIGH) ? q.s2.ctl[i] : 2'b00;
            bad = (q.s2.par_ctl != LVL_LOW) & ~(^{q.s2.par[i], q.s2.chr[i], cbits});
            // word sync needs special select, otherwise a special code
            if (!enc) begin
                k = K_DATA;
            end else if (q.s2.ctl[i] == K_WSYNC && !n.ch[i].sc) begin
                k = K_SPECIAL;
            end else begin
                k = sptx_kind_t'(q.s2.ctl[i]);
            end
            // capture register
            n.ch[i].valid = cap_ev[i];
            if (cap_ev[i]) begin
                n.ch[i].viol = bad;
                if (bad) begin
                    // a bad character leaves as C0.7 so the far end rejects it
                    n.ch[i].kind = enc ? K_SPECIAL : K_DATA;
                    n.ch[i].word = enc ? {K_SPECIAL, VIOL_BYTE} : VIOL_LINE_CODE;
                end else begin
                    n.ch[i].kind = k;
                    // bypass: control bits are the top of the raw 10-bit word
                    n.ch[i].word = {q.s2.ctl[i], q.s2.chr[i]};
                end
            end
            wsync = cap_ev[i] & enc & ~bad & (k == K_WSYNC);
            // parity event waits for the next character boundary, set wins
            n.ch[i].par_pend = (q.ch[i].par_pend & ~ref_tick) | (cap_ev[i] & bad);
            // bist pass counter, runs on character boundaries
            bist_hit = q.s2.bist_en[i] & ref_tick & (q.ch[i].bist_cnt == BIST_LAST);
            if (!q.s2.bist_en[i]) begin
                n.ch[i].bist_cnt = 9'h000;
            end else if (ref_tick) begin
                n.ch[i].bist_cnt = bist_hit ? 9'h000 : q.ch[i].bist_cnt + 9'h001;
            end
            // fill offset: writes on capture, reads on character boundary
            ovf = buf_en & cap_ev[i] & ~ref_tick & (q.ch[i].occ == OCC_TOP);
            unf = buf_en & ref_tick & ~cap_ev[i] & (q.ch[i].occ == OCC_BOT);
            if (!buf_en || recenter) begin
                n.ch[i].occ = OCC_CENTER;
            end else if (cap_ev[i] && !ref_tick && !ovf) begin
                n.ch[i].occ = q.ch[i].occ + 3'h1;
            end else if (ref_tick && !cap_ev[i] && !unf) begin
                n.ch[i].occ = q.ch[i].occ - 3'h1;
            end
            // slip fault is sticky; a new slip beats a same-cycle clear
            n.ch[i].align_flt = ovf | unf | (q.ch[i].align_flt & ~(wsync | recenter));
            // fault output only moves on a character boundary
            if (ref_tick) begin
                n.ch[i].fault = q.ch[i].par_pend | bist_hit | n.ch[i].align_flt;
            end
        end
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    fault_ref_edge_a: assert property ($changed(chan_fault_out[0]) |-> $past(ref_tick))
        else $error("fault moved off a reference edge");
    par_pulse_a: assert property (ref_tick && q.ch[0].par_pend |=> chan_fault_out[0])
        else $error("parity error not shown on fault");
    viol_sub_a: assert property (chan_word_valid[0] && chan_word_viol[0]
        |-> chan_word_out[0] == VIOL_LINE_CODE || chan_word_out[0] == {K_SPECIAL, VIOL_BYTE})
        else $error("bad character not replaced");
    bist_wrap_a: assert property (ref_tick && q.s2.bist_en[0] && q.ch[0].bist_cnt == BIST_LAST
        |=> chan_fault_out[0] && q.ch[0].bist_cnt == 9'h000)
        else $error("bist pass pulse missing");
    // select low with full rate: the buffer must sit centred and idle
    buf_enable_a: assert property (q.s2.clk_sel == LVL_LOW && !q.s2.half_rate
        |=> q.ch[0].occ == OCC_CENTER)
        else $error("bypassed phase buffer not centred");
    align_hold_a: assert property (q.ch[0].align_flt && !recenter && !cap_ev[0]
        |=> q.ch[0].align_flt && (chan_fault_out[0] || !$past(ref_tick)))
        else $error("slip fault dropped early");
    cap_valid_a: assert property (cap_ev[0]
        |=> chan_word_valid[0] ##1 (!chan_word_valid[0] || $past(cap_ev[0])))
        else $error("capture did not present a character");
    bypass_word_a: assert property (cap_ev[0] && !enc
        && (q.s2.par_ctl == LVL_LOW || ^{q.s2.par[0], q.s2.chr[0], q.s2.ctl[0]})
        |=> chan_word_out[0][9:8] == $past(q.s2.ctl[0]) && chan_word_out[0][7:0] == $past(q.s2.chr[0]))
        else $error("bypass word not control and data");
    parity_a: assert property (cap_ev[0] && enc && q.s2.par_ctl == LVL_MID
        && !(^{q.s2.par[0], q.s2.chr[0]}) |=> chan_word_viol[0])
        else $error("even parity not flagged");
    sc_mid_a: assert property (q.s2.clk_sel == LVL_MID && clk_rise[0] |=> chan_sc_out[1] == $past(q.s2.sc))
        else $error("special select not on channel A clock");
    // an armed recenter request must not clear a slip while the buffer is bypassed
    ignore_rst_a: assert property (!buf_en && ref_rise && !q.s2.recenter_n && q.low_cnt == RECENTER_ARM
        && q.ch[0].align_flt && !(enc && q.s2.ctl[0] == K_WSYNC) |=> q.ch[0].align_flt)
        else $error("recenter acted with buffer bypassed");

endmodule

// ===== sim/sptx_host.sv
// sptx_host: host model with free-running link clocks and character pins.
// assumes the bench hands it the next character; pins move on reference falls.
`timescale 1ns/1ps
module sptx_host
    import sptx_pkg::*;
(
    // next character from the bench
    input wire logic [NCH-1:0][7:0] nxt_chr,
    input wire logic [NCH-1:0][1:0] nxt_ctl,
    input wire logic [NCH-1:0] nxt_par,
    // link clocks
    output logic ref_clock_in,
    output logic [NCH-1:0] chan_input_clock,
    // character pins
    output logic [NCH-1:0][7:0] chan_char_in,
    output logic [NCH-1:0][1:0] chan_ctl_bits,
    output logic [NCH-1:0] chan_odd_par_in
);
    // ****
    // clocks: 80 ns, channel clocks 20 ns behind the reference
    // ****
    initial begin
        ref_clock_in = 1'b0;
        chan_char_in = '0;
        chan_ctl_bits = '0;
        chan_odd_par_in = '1;
        #3;
        forever #40 ref_clock_in = ~ref_clock_in;
    end
    initial begin
        chan_input_clock = '0;
        #23;
        forever #40 chan_input_clock = ~chan_input_clock;
    end
    // pins move half a period from each reference rise and 20 ns after each channel clock rise, so they never race a capturing rise
    always @(negedge ref_clock_in) begin
        chan_char_in <= nxt_chr;
        chan_ctl_bits <= nxt_ctl;
        chan_odd_par_in <= nxt_par;
    end
endmodule

// ===== sim/testbench.sv
// testbench: hand-written scenarios for the transmit input stage.
// assumes the host model drives the pins; configuration moves on clk rises.
`timescale 1ns/1ps
module testbench
    import sptx_pkg::*;
;
    localparam logic [9:0] VCODE = 10'h2a5; // bypass violation pattern, arbitrary
    logic clk, rst_n, sc, hr, rcn, rclk;
    sptx_lvl_t sel, pctl;
    logic [1:0] mode;
    logic [NCH-1:0] bist, cclk, par_q, par_pin, fault, valid, viol, sc_out;
    logic [NCH-1:0][7:0] chr_q, chr_pin;
    logic [NCH-1:0][1:0] ctl_q, ctl_pin;
    logic [NCH-1:0][9:0] word;
    sptx_kind_t [NCH-1:0] kind;
    int num_errors = 0;
    int total_checks = 0;
    int g, w, w2;
    // ****
    // clock, host and design
    // ****
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    sptx_host host (.nxt_chr(chr_q), .nxt_ctl(ctl_q), .nxt_par(par_q), .ref_clock_in(rclk),
        .chan_input_clock(cclk), .chan_char_in(chr_pin), .chan_ctl_bits(ctl_pin), .chan_odd_par_in(par_pin));
    sptx_input_stage #(.VIOL_LINE_CODE(VCODE)) uut (.clk(clk), .rst_n(rst_n), .ref_clock_in(rclk),
        .chan_input_clock(cclk), .chan_char_in(chr_pin), .chan_ctl_bits(ctl_pin),
        .chan_odd_par_in(par_pin), .special_char_sel(sc), .input_clock_select(sel), .ref_half_rate(hr),
        .encoder_mode_sel(mode), .parity_check_ctl(pctl), .phase_buffer_recenter_n(rcn),
        .chan_bist_en(bist), .chan_fault_out(fault), .chan_word_out(word), .chan_word_valid(valid),
        .chan_word_kind(kind), .chan_word_viol(viol), .chan_sc_out(sc_out));
    // ****
    // shared tasks
    // ****
    task automatic wrap_up;
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [9:0] e, input logic [9:0] s);
        total_checks++;
        if (e !== s) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic check_rng(input string n, input int lo, input int hi, input int s);
        total_checks++;
        if (s < lo || s > hi) begin
            num_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, s);
        end
    endtask
    // the second capture pulse surely holds the new pins
    task automatic wait_word(input int ch);
        int n;
        n = 0;
        for (int i = 0; i < 300 && n < 2; i++) begin
            @(posedge clk);
            #1;
            if (valid[ch] === 1'b1) n++;
        end
        check("valid_seen", 10'h002, n[9:0]);
    endtask
    task automatic send(input int ch, input logic [1:0] c, input logic [7:0] b);
        logic inc;
        @(posedge clk);
        inc = (pctl == LVL_HIGH) || (mode == MODE_BYPASS);
        chr_q[ch] <= b;
        ctl_q[ch] <= c;
        par_q[ch] <= ~((^b) ^ (inc & (^c)));
        wait_word(ch);
    endtask
    // gap before the next fault rise, then its width
    task automatic pulse(input int ch, output int gp, output int wd);
        gp = 0;
        wd = 0;
        while (fault[ch] !== 1'b1 && gp < 9000) begin
            @(posedge clk);
            #1;
            gp++;
        end
        while (fault[ch] === 1'b1 && wd < 100) begin
            @(posedge clk);
            #1;
            wd++;
        end
    endtask
    // one wrong parity on channel A, restored once the violation shows so one character is bad
    task automatic bad_char(input logic [9:0] exp, input sptx_kind_t ek);
        @(posedge clk);
        par_q[0] <= ~par_q[0];
        for (int i = 0; i < 300 && viol[0] !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check("word_viol", exp, word[0]);
        // kind is looked at now, before the next capture overwrites it
        check("viol_kind", {8'h00, ek}, {8'h00, kind[0]});
        par_q[0] <= ~par_q[0];
        pulse(0, g, w);
        check_rng("parity_fault_width", 15, 17, w);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_encode;
        sptx_kind_t ek;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            sc <= (k == 4);
            send(0, (k > 3) ? 2'h3 : k[1:0], 8'h50 + k[7:0]);
            ek = (k == 3) ? K_SPECIAL : (k == 4) ? K_WSYNC : sptx_kind_t'(k[1:0]);
            check("word", {(k > 3) ? 2'h3 : k[1:0], 8'h50 + k[7:0]}, word[0]);
            check("kind", {8'h00, ek}, {8'h00, kind[0]});
            check("viol", 10'h000, {9'h000, viol[0]});
        end
        check("sc_out", 10'h001, {9'h000, sc_out[0]});
        check_rng("ref_phase", 10, 29, int'(($time - 43) % 80));
        bad_char({2'h1, VIOL_BYTE}, K_SPECIAL);
        @(posedge clk);
        pctl <= LVL_HIGH;
        send(0, 2'h1, 8'h81);
        check("viol_high", 10'h000, {9'h000, viol[0]});
    endtask
    task automatic t_bypass;
        @(posedge clk);
        mode <= MODE_BYPASS;
        send(0, 2'h2, 8'h3c);
        check("raw_word", 10'h23c, word[0]);
        bad_char(VCODE, K_DATA);
    endtask
    task automatic t_rate(input logic half, input int exp);
        int n;
        n = 0;
        @(posedge clk);
        hr <= half;
        repeat (40) @(posedge clk);
        for (int i = 0; i < 320; i++) begin
            @(posedge clk);
            #1;
            if (valid[0] === 1'b1) n++;
        end
        check_rng("captures", exp - 1, exp + 1, n);
    endtask
    task automatic t_bist;
        @(posedge clk);
        mode <= 2'h1;
        pctl <= LVL_LOW;
        bist[1] <= 1'b1;
        pulse(1, g, w);
        pulse(1, w2, g);
        check_rng("bist_period", 8174, 8178, w + w2);
        check_rng("bist_width", 15, 17, w);
    endtask
    task automatic t_select(input sptx_lvl_t s, input int ch, input logic scv);
        @(posedge clk);
        sel <= s;
        sc <= scv;
        send(ch, 2'h0, 8'h11);
        check_rng("chan_phase", 30, 60, int'(($time - 43) % 80));
        check("sc_mid", {9'h000, scv}, {9'h000, sc_out[ch]});
    endtask
    // half-rate reads outrun channel A's own clock, so its buffer runs dry
    task automatic t_slip;
        @(posedge clk);
        sel <= LVL_MID;
        hr <= 1'b1;
        repeat (400) @(posedge clk);
        #1;
        check("slip_fault", 10'h001, {9'h000, fault[0]});
        // buffer bypassed: a long recenter request must be ignored
        @(posedge clk);
        sel <= LVL_LOW;
        hr <= 1'b0;
        rcn <= 1'b0;
        repeat (60) @(posedge clk);
        #1;
        check("bypassed_recenter", 10'h001, {9'h000, fault[0]});
        // balanced clocks again: the slip stays until recentered
        @(posedge clk);
        rcn <= 1'b1;
        sel <= LVL_MID;
        repeat (60) @(posedge clk);
        #1;
        check("slip_sticky", 10'h001, {9'h000, fault[0]});
        // held low over at least two reference rises
        @(posedge clk);
        rcn <= 1'b0;
        repeat (60) @(posedge clk);
        rcn <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        check("recentered", 10'h000, {9'h000, fault[0]});
    endtask
    // ****
    // main sequence and watchdog
    // ****
    initial begin
        {rst_n, sc, hr, bist, chr_q, ctl_q} = '0;
        {rcn, par_q} = '1;
        sel = LVL_LOW;
        pctl = LVL_MID;
        mode = 2'h1;
        repeat (20) @(posedge clk);
        #1;
        check("reset_out", 10'h000, {2'h0, fault, valid});
        @(posedge clk);
        rst_n <= 1'b1;
        t_encode();
        t_bypass();
        t_rate(1'b0, 20);
        t_rate(1'b1, 40);
        @(posedge clk);
        hr <= 1'b0;
        t_bist();
        t_select(LVL_MID, 2, 1'b0);
        t_select(LVL_HIGH, 3, 1'b1);
        t_slip();
        wrap_up();
    end
    // the whole run needs about 20000 clocks
    initial begin
        #300000;
        num_errors++;
        wrap_up();
    end
endmodule
